// ### rtl/cpd_regs.vh
// Constants for the command pulse input decoder: register map, field
// positions, reset values and timing counts.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef CPD_REGS_VH
`define CPD_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CPD_OFS_CFG     8'h00
`define CPD_OFS_CTRL    8'h04
`define CPD_OFS_ACTIVE  8'h08
`define CPD_OFS_POS     8'h0C

// ----------------------------------------------------------------------
// Field layout shared by the pending and active settings registers, plus the control register's apply bit
// ----------------------------------------------------------------------
`define CPD_SRC_LSB     0
`define CPD_SRC_MSB     1
`define CPD_DIR_BIT     2
`define CPD_FMT_LSB     4
`define CPD_FMT_MSB     5
`define CPD_CTRL_APPLY  0

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define CPD_SRC_OPTO    2'h0
`define CPD_SRC_LD      2'h1
`define CPD_SRC_SLOW    2'h2
`define CPD_SRC_RST     2'h0
`define CPD_DIR_RST     1'b0
`define CPD_FMT_RST     2'h1
`define CPD_FMT_QUAD0   2'h0
`define CPD_FMT_PULSES  2'h1
`define CPD_FMT_QUAD2   2'h2
`define CPD_FMT_PDIR    2'h3
`define CPD_RESP_OKAY   2'h0
`define CPD_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CPD_CLK_KHZ     100000
`define CPD_SLOW_KPPS   250
// A quarter of one period at the slow rate must pass with a steady level.
`define CPD_FLT_CYC     ((`CPD_CLK_KHZ / `CPD_SLOW_KPPS) / 4)

`endif

// ### rtl/cpd_sync.v
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs change no faster than the destination clock.
`timescale 1ns/1ps
`default_nettype none

module cpd_sync #(
    parameter W = 8
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Levels
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    reg [W-1:0] meta_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule // cpd_sync

`default_nettype wire

// ### rtl/cpd_decoder.v
// Command pulse input decoder with an AXI4-Lite register slave.
// Assumes differential pulse/sign pairs from a host motion controller,
// asynchronous to aclk, and a single 100 MHz clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "cpd_regs.vh"

module cpd_decoder #(
    parameter ADDR_W = 8
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Optocoupled pair
    input wire opto_pulse_pos,
    input wire opto_pulse_neg,
    input wire opto_sign_pos,
    input wire opto_sign_neg,
    // Line-driver pair
    input wire ld_pulse_pos,
    input wire ld_pulse_neg,
    input wire ld_sign_pos,
    input wire ld_sign_neg,
    // Decoded steps
    output reg step_pulse_reg,
    output reg step_dir_reg,
    // AXI4-Lite write address and data
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ------------------------------------------------------------------
    // Settings
    // ------------------------------------------------------------------
    reg [1:0] cfg_src_reg;
    reg cfg_dir_reg;
    reg [1:0] cfg_fmt_reg;
    reg [1:0] act_src_reg;
    reg act_dir_reg;
    reg [1:0] act_fmt_reg;
    reg restart_reg;
    reg signed [31:0] pos_reg;

    function [31:0] pack_cfg;
        input [1:0] src;
        input dir;
        input [1:0] fmt;
        begin
            pack_cfg = 32'h0000_0000;
            pack_cfg[`CPD_SRC_MSB:`CPD_SRC_LSB] = src;
            pack_cfg[`CPD_DIR_BIT] = dir;
            pack_cfg[`CPD_FMT_MSB:`CPD_FMT_LSB] = fmt;
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (strb[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisation and source selection
    // ------------------------------------------------------------------
    wire [7:0] pins_sync;
    cpd_sync #(
        .W(8)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({ld_sign_neg, ld_sign_pos, ld_pulse_neg, ld_pulse_pos,
            opto_sign_neg, opto_sign_pos, opto_pulse_neg, opto_pulse_pos}),
        .q(pins_sync)
    );

    // A pair reads high only while its two wires disagree the right way.
    wire opto_pulse = pins_sync[0] & ~pins_sync[1];
    wire opto_sign = pins_sync[2] & ~pins_sync[3];
    wire ld_pulse = pins_sync[4] & ~pins_sync[5];
    wire ld_sign = pins_sync[6] & ~pins_sync[7];
    wire use_ld = (act_src_reg == `CPD_SRC_LD);
    wire raw_a = use_ld ? ld_pulse : opto_pulse;
    wire raw_b = use_ld ? ld_sign : opto_sign;
    wire slow_mode = (act_src_reg == `CPD_SRC_SLOW);

    // ------------------------------------------------------------------
    // Slow-source noise filter
    // ------------------------------------------------------------------
    // In the slow mode a level must hold a quarter period at 250 kpps
    // before it is believed; this rejects noise that the fast path
    // would count, at the price of capping the usable rate.
    localparam integer FLT_CYC_I = `CPD_FLT_CYC;
    localparam [7:0] FLT_CYC = FLT_CYC_I[7:0];
    reg [7:0] flt_cnt_reg [0:1];
    reg [1:0] flt_reg;
    wire [1:0] raw_ab = {raw_b, raw_a};
    integer f;

    always @(posedge aclk)
    begin
        for (f = 0; f < 2; f = f + 1)
        begin
            if (!aresetn)
            begin
                flt_cnt_reg[f] <= 8'h00;
                flt_reg[f] <= 1'b0;
            end
            else if (!slow_mode || raw_ab[f] == flt_reg[f])
            begin
                flt_cnt_reg[f] <= 8'h00;
                flt_reg[f] <= raw_ab[f];
            end
            else if (flt_cnt_reg[f] >= FLT_CYC - 8'h01)
            begin
                flt_cnt_reg[f] <= 8'h00;
                flt_reg[f] <= raw_ab[f];
            end
            else
                flt_cnt_reg[f] <= flt_cnt_reg[f] + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Format decoding
    // ------------------------------------------------------------------
    reg a_q_reg;
    reg b_q_reg;
    reg prime_reg;
    reg step_v;
    reg step_up;
    wire a = flt_reg[0];
    wire b = flt_reg[1];
    wire a_ed = a ^ a_q_reg;
    wire b_ed = b ^ b_q_reg;
    wire a_rise = a & ~a_q_reg;
    wire b_rise = b & ~b_q_reg;

    always @*
    begin
        step_v = 1'b0;
        step_up = 1'b0;
        case (act_fmt_reg)
            `CPD_FMT_QUAD0, `CPD_FMT_QUAD2:
            begin
                // Both phases moving at once has no defined sense.
                step_v = a_ed ^ b_ed;
                step_up = (a_ed ? (a == b) : (a != b)) ^ act_dir_reg;
            end
            `CPD_FMT_PULSES:
            begin
                step_v = a_rise ^ b_rise;
                step_up = a_rise ^ act_dir_reg;
            end
            `CPD_FMT_PDIR:
            begin
                step_v = a_rise;
                step_up = b ^ act_dir_reg;
            end
            default:
            begin
                step_v = 1'b0;
                step_up = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Active settings and step outputs
    // ------------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            act_src_reg <= `CPD_SRC_RST;
            act_dir_reg <= `CPD_DIR_RST;
            act_fmt_reg <= `CPD_FMT_RST;
            a_q_reg <= 1'b0;
            b_q_reg <= 1'b0;
            prime_reg <= 1'b1;
            step_pulse_reg <= 1'b0;
            step_dir_reg <= 1'b0;
        end
        else
        begin
            if (restart_reg)
            begin
                act_src_reg <= cfg_src_reg;
                act_dir_reg <= cfg_dir_reg;
                act_fmt_reg <= cfg_fmt_reg;
            end
            a_q_reg <= a;
            b_q_reg <= b;
            // After a restart the old levels are stale, so one cycle is
            // spent learning the lines before any edge counts.
            prime_reg <= restart_reg;
            step_pulse_reg <= step_v & ~prime_reg & ~restart_reg;
            step_dir_reg <= step_v ? step_up : step_dir_reg;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    reg aw_held_reg;
    reg w_held_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire [7:0] wa = aw_addr_reg[7:0];
    wire [7:0] ra = s_axi_araddr[7:0];
    wire [31:0] cfg_new = merge(pack_cfg(cfg_src_reg, cfg_dir_reg,
        cfg_fmt_reg), w_data_reg, w_strb_reg);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CPD_RESP_OKAY;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= {ADDR_W{1'b0}};
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            cfg_src_reg <= `CPD_SRC_RST;
            cfg_dir_reg <= `CPD_DIR_RST;
            cfg_fmt_reg <= `CPD_FMT_RST;
            restart_reg <= 1'b0;
            pos_reg <= 32'sh0000_0000;
        end
        else
        begin
            restart_reg <= 1'b0;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_reg <= s_axi_awaddr;
                aw_held_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_held_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (step_pulse_reg)
                pos_reg <= step_dir_reg ? pos_reg + 32'sh0000_0001
                                        : pos_reg - 32'sh0000_0001;
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `CPD_RESP_OKAY;
                case (wa)
                    `CPD_OFS_CFG:
                    begin
                        // An out-of-range source keeps the old choice.
                        if (cfg_new[`CPD_SRC_MSB:`CPD_SRC_LSB] != 2'h3)
                            cfg_src_reg <= cfg_new[`CPD_SRC_MSB:`CPD_SRC_LSB];
                        cfg_dir_reg <= cfg_new[`CPD_DIR_BIT];
                        cfg_fmt_reg <= cfg_new[`CPD_FMT_MSB:`CPD_FMT_LSB];
                    end
                    `CPD_OFS_CTRL:
                        restart_reg <= w_strb_reg[0] &
                            w_data_reg[`CPD_CTRL_APPLY];
                    `CPD_OFS_ACTIVE:
                        s_axi_bresp <= `CPD_RESP_OKAY;
                    `CPD_OFS_POS:
                        pos_reg <= merge(pos_reg, w_data_reg, w_strb_reg);
                    default:
                        s_axi_bresp <= `CPD_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CPD_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CPD_RESP_OKAY;
            case (ra)
                `CPD_OFS_CFG:
                    s_axi_rdata <= pack_cfg(cfg_src_reg, cfg_dir_reg,
                        cfg_fmt_reg);
                `CPD_OFS_CTRL:
                    s_axi_rdata <= 32'h0000_0000;
                `CPD_OFS_ACTIVE:
                    s_axi_rdata <= pack_cfg(act_src_reg, act_dir_reg,
                        act_fmt_reg);
                `CPD_OFS_POS:
                    s_axi_rdata <= pos_reg;
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `CPD_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // cpd_decoder

`default_nettype wire

// ### tb/cpd_decoder_monitor.sv
// Checker for the command pulse decoder, bound into cpd_decoder.
// Assumes it sees only the decoder's ports and one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "cpd_regs.vh"

module cpd_decoder_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pulse and sign pairs
    input wire logic opto_pulse_pos,
    input wire logic opto_pulse_neg,
    input wire logic opto_sign_pos,
    input wire logic opto_sign_neg,
    input wire logic ld_pulse_pos,
    input wire logic ld_pulse_neg,
    input wire logic ld_sign_pos,
    input wire logic ld_sign_neg,
    // Steps and register bus
    input wire logic step_pulse_reg,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // A step must trace back to a pin change a few cycles earlier; the
    // bound leaves room for the slow-source stability filter.
    logic [7:0] pins_reg;
    logic [7:0] quiet_reg;
    always_ff @(posedge aclk)
    begin
        pins_reg <= {opto_pulse_pos, opto_pulse_neg, opto_sign_pos,
            opto_sign_neg, ld_pulse_pos, ld_pulse_neg, ld_sign_pos,
            ld_sign_neg};
        if (!aresetn || pins_reg != {opto_pulse_pos, opto_pulse_neg,
            opto_sign_pos, opto_sign_neg, ld_pulse_pos, ld_pulse_neg,
            ld_sign_pos, ld_sign_neg})
            quiet_reg <= 8'h00;
        else if (quiet_reg != 8'hff)
            quiet_reg <= quiet_reg + 8'h01;
    end

    chk_reset_idle:
        assert property ($rose(aresetn) |-> !step_pulse_reg && !s_axi_bvalid
            && !s_axi_rvalid && s_axi_arready && s_axi_awready)
        else $error("outputs not idle after reset");
    chk_step_cause:
        assert property (step_pulse_reg |-> quiet_reg >= 8'h02
            && quiet_reg <= 8'h78)
        else $error("step without a recent pin change");
    chk_b_latency:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
            && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    chk_b_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
            && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped");
    chk_ar_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
            && !s_axi_arready)
        else $error("read not answered next cycle");
    chk_aw_refused:
        assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    chk_err_zero:
        assert property (s_axi_rvalid && s_axi_rresp == `CPD_RESP_SLVERR
            |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read returns data");
endmodule // cpd_decoder_monitor

bind cpd_decoder cpd_decoder_monitor i_cpd_decoder_monitor (
    .aclk, .aresetn, .opto_pulse_pos, .opto_pulse_neg, .opto_sign_pos,
    .opto_sign_neg, .ld_pulse_pos, .ld_pulse_neg, .ld_sign_pos,
    .ld_sign_neg, .step_pulse_reg, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ### tb/cpd_host_model.sv
// Host motion controller model driving either of two differential pairs.
// Assumes one caller at a time; the gap sets the pulse rate.
`timescale 1ns/1ps
`default_nettype none

module cpd_host_model (
    // Clock
    input wire logic aclk,
    // Differential pairs
    output wire logic opto_pulse_pos,
    output wire logic opto_pulse_neg,
    output wire logic opto_sign_pos,
    output wire logic opto_sign_neg,
    output wire logic ld_pulse_pos,
    output wire logic ld_pulse_neg,
    output wire logic ld_sign_pos,
    output wire logic ld_sign_neg
);
    logic a_reg = 1'b0;
    logic b_reg = 1'b0;
    logic sel_reg = 1'b0;
    logic [1:0] ph_reg = 2'h0;

    // The pair not in use rests at its low level, never floating.
    assign opto_pulse_pos = !sel_reg && a_reg;
    assign opto_pulse_neg = !opto_pulse_pos;
    assign opto_sign_pos = !sel_reg && b_reg;
    assign opto_sign_neg = !opto_sign_pos;
    assign ld_pulse_pos = sel_reg && a_reg;
    assign ld_pulse_neg = !ld_pulse_pos;
    assign ld_sign_pos = sel_reg && b_reg;
    assign ld_sign_neg = !ld_sign_pos;

    task automatic idle(input logic sel);
        @(posedge aclk);
        a_reg <= 1'b0;
        b_reg <= 1'b0;
        ph_reg <= 2'h0;
        sel_reg <= sel;
    endtask

    task automatic step(input logic [1:0] fmt, input logic inv,
        input logic fwd, input int gap);
        logic p;
        logic [1:0] nx;
        p = fwd ^ inv;
        nx = p ? ph_reg + 2'h1 : ph_reg - 2'h1;
        @(posedge aclk);
        if (!fmt[0])
        begin
            // Counting up changes B first, so B leads A.
            ph_reg <= nx;
            a_reg <= nx[1];
            b_reg <= nx[1] ^ nx[0];
        end
        else if (!fmt[1])
        begin
            a_reg <= p;
            b_reg <= !p;
            repeat (gap) @(posedge aclk);
            a_reg <= 1'b0;
            b_reg <= 1'b0;
        end
        else
        begin
            b_reg <= p;
            repeat (gap) @(posedge aclk);
            a_reg <= 1'b1;
            repeat (gap) @(posedge aclk);
            a_reg <= 1'b0;
        end
        repeat (gap) @(posedge aclk);
    endtask
endmodule // cpd_host_model
`default_nettype wire

// ### tb/tb_cpd_decoder.sv
// Self-checking bench for the command pulse decoder.
// Assumes the design, checker and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cpd_regs.vh"

module tb_cpd_decoder;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    wire opto_pulse_pos, opto_pulse_neg, opto_sign_pos, opto_sign_neg;
    wire ld_pulse_pos, ld_pulse_neg, ld_sign_pos, ld_sign_neg;
    wire step_pulse_reg, step_dir_reg, s_axi_awready, s_axi_wready;
    wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0] resp;
    logic [31:0] rd;
    int num_errors = 0, checks = 0, net = 0;

    always #5 aclk = ~aclk;

    cpd_decoder i_cpd_decoder (.aclk, .aresetn, .opto_pulse_pos,
        .opto_pulse_neg, .opto_sign_pos, .opto_sign_neg, .ld_pulse_pos,
        .ld_pulse_neg, .ld_sign_pos, .ld_sign_neg, .step_pulse_reg,
        .step_dir_reg, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    cpd_host_model i_cpd_host_model (.aclk, .opto_pulse_pos,
        .opto_pulse_neg, .opto_sign_pos, .opto_sign_neg, .ld_pulse_pos,
        .ld_pulse_neg, .ld_sign_pos, .ld_sign_neg);

    always @(posedge aclk)
    begin
        if (step_pulse_reg === 1'b1)
            net <= step_dir_reg ? net + 1 : net - 1;
    end

    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        resp = s_axi_bresp;
        check("write_done", n < 50, 32'h0000_0001);
    endtask

    task automatic axi_read(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        check("read_done", n < 50, 32'h0000_0001);
    endtask

    task automatic setup(input logic [1:0] src, input logic inv,
        input logic [1:0] fmt, input logic sel);
        logic [31:0] cfg;
        cfg = {26'h0, fmt, 1'b0, inv, src};
        i_cpd_host_model.idle(sel);
        repeat (150) @(posedge aclk);
        axi_write(`CPD_OFS_CFG, cfg);
        check("cfg_resp", resp, `CPD_RESP_OKAY);
        axi_write(`CPD_OFS_CTRL, 32'h0000_0001);
        axi_read(`CPD_OFS_ACTIVE);
        check("active", rd, cfg);
        axi_write(`CPD_OFS_POS, 32'h0000_0000);
        net <= 0;
    endtask

    task automatic drive(input logic [1:0] fmt, input logic inv,
        input int n, input int gap, input logic seen_pair);
        int exp;
        int k;
        logic fwd;
        exp = 0;
        for (k = 0; k < n; k++)
        begin
            fwd = $urandom % 2;
            i_cpd_host_model.step(fmt, inv, fwd, gap);
            if (seen_pair) exp += fwd ? 1 : -1;
        end
        repeat (150) @(posedge aclk);
        axi_read(`CPD_OFS_POS);
        check("position", rd, exp);
        check("step_sum", net, exp);
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        void'($urandom(1));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`CPD_OFS_CFG);
        check("cfg_reset", rd, 32'h0000_0010);
        axi_read(8'h10);
        check("unmapped", resp, `CPD_RESP_SLVERR);
        axi_write(8'h10, 32'h0000_0001);
        check("unmapped_wr", resp, `CPD_RESP_SLVERR);
        $display("test reset done");
        for (int m = 0; m < 16; m++)
        begin
            setup({1'b0, m[3]}, m[2], m[1:0], m[3]);
            drive(m[1:0], m[2], 4 + $urandom % 9, 6 + $urandom % 6, 1'b1);
            $display("test format %0d done", m);
        end
        // Pulses on the pair that is not selected must be ignored.
        setup(`CPD_SRC_OPTO, 1'b0, `CPD_FMT_PULSES, 1'b1);
        drive(`CPD_FMT_PULSES, 1'b0, 8, 6, 1'b0);
        $display("test pair select done");
        // Pending settings change nothing until they are applied.
        setup(`CPD_SRC_OPTO, 1'b0, `CPD_FMT_PULSES, 1'b0);
        axi_write(`CPD_OFS_CFG, 32'h0000_0034);
        drive(`CPD_FMT_PULSES, 1'b0, 6, 7, 1'b1);
        axi_read(`CPD_OFS_CFG);
        check("cfg_pending", rd, 32'h0000_0034);
        $display("test latch done");
        // Slow source with a 601-cycle step period, longer than the 400-cycle period of the 250 kpps limit.
        setup(`CPD_SRC_SLOW, 1'b0, `CPD_FMT_PDIR, 1'b0);
        drive(`CPD_FMT_PDIR, 1'b0, 5, 200, 1'b1);
        $display("test slow source done");
        final_report();
    end

    initial
    begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        final_report();
    end
endmodule // tb_cpd_decoder
`default_nettype wire
